// file: design/hpf_top.sv
// Hot-plug fault latch, power-good delay, debounce and AHB-Lite registers
//
// Contract
// - The fault flag pin is driven low and stays latched while outputs are shut by a fault.
// - An overcurrent lasting past the overcurrent timeout is a fault that sets the flag.
// - A die overtemperature shuts the outputs down and sets the flag.
// - A main-output fault is cleared by a low-then-high toggle of the main enable.
// - An auxiliary fault is cleared only after both enables were low together, then raised.
// - In auto-restart mode the flag is released when the next power-on cycle starts.
// - Power good goes low only after the delay from all outputs being fully on.
// - With the timeout program input open the overcurrent timeout is 11 ms.
// - The general output copies the general input after it held a new level for 4 ms.
// - With the delay program input open the power-good delay is 160 ms.
// - Outputs follow enables after card-present held low 4 ms, and drop at once on removal.
// - An auxiliary fault turns off all outputs, a main fault only the main rails output.
// - Force-on low turns all outputs on while supplies are in range, over all else.

`timescale 1ns/100ps
`default_nettype none

module hpf_top #(
  parameter int unsigned TICK_CYCLES = hpf_pkg::TICK_CYCLES
) (
  input  wire  logic        core_clk_i,       // 200 MHz clock
  input  wire  logic        rst_i,            // Sync reset, aux supply UVLO
  input  wire  logic        hsel_i,           // AHB select
  input  wire  logic [31:0] haddr_i,          // AHB address
  input  wire  logic [1:0]  htrans_i,         // AHB transfer type
  input  wire  logic        hwrite_i,         // AHB write
  input  wire  logic [2:0]  hsize_i,          // AHB size
  input  wire  logic [31:0] hwdata_i,         // AHB write data
  input  wire  logic        hready_i,         // AHB bus ready
  output var   logic        hreadyout_o,      // AHB slave ready
  output var   logic        hresp_o,          // AHB response
  output var   logic [31:0] hrdata_o,         // AHB read data
  input  wire  logic        main_enable_i,    // Main rails enable pin
  input  wire  logic        aux_rail_enable_i, // Aux rail enable pin
  input  wire  logic        card_present_n_i, // Card present, low = present
  input  wire  logic        force_all_on_n_i, // Force all on, active low
  input  wire  logic        gen_in_i,         // General digital input
  input  wire  logic        oc_main_i,        // Main rail overcurrent
  input  wire  logic        oc_aux_i,         // Aux rail overcurrent
  input  wire  logic        overtemp_i,       // Die overtemperature
  input  wire  logic        main_full_i,      // Main switches fully enhanced
  input  wire  logic        aux_full_i,       // Aux switch fully enhanced
  input  wire  logic        main_supply_ok_i, // Main supplies above UVLO
  input  wire  logic        oct_prog_open_i,  // Timeout program input open
  input  wire  logic        pgd_prog_open_i,  // Delay program input open
  output var   logic        main_on_o,        // Main rails switch on
  output var   logic        aux_on_o,         // Aux rail switch on
  output var   logic        fault_n_o,        // Fault pin level (always 0)
  output var   logic        fault_n_oe_o,     // Fault pin pulled low
  output var   logic        power_good_n_o,   // Power good pin level (always 0)
  output var   logic        power_good_n_oe_o, // Power good pin pulled low
  output var   logic        gen_out_o,        // Debounced general output
  output var   logic        irq_o             // Level interrupt
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [hpf_pkg::PIN_W-1:0] pin_raw;
  logic [hpf_pkg::PIN_W-1:0] pin_q;
  hpf_pkg::hpf_pins_t        p;

  assign pin_raw = {main_enable_i, aux_rail_enable_i, card_present_n_i,
                    force_all_on_n_i, gen_in_i, oc_main_i, oc_aux_i,
                    overtemp_i, main_full_i, aux_full_i, main_supply_ok_i,
                    oct_prog_open_i, pgd_prog_open_i};

  // A level counts once the second and third stages agree
  for (genvar i = 0; i < hpf_pkg::PIN_W; i++)
  begin : g_sync
    logic s1;
    logic s2;
    logic s3;
    logic q;
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
      begin
        {s1, s2, s3, q} <= {4{hpf_pkg::PIN_IDLE[i]}};
      end
      else
      begin
        s1 <= pin_raw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3)
          q <= s3;
      end
    end
    assign pin_q[i] = q;
  end

  assign p = hpf_pkg::hpf_pins_t'(pin_q);

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [17:0] div;
  logic        tick;

  assign tick = (div == 18'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || tick)
      div <= 18'h00000;
    else
      div <= div + 18'h00001;
  end

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  logic                     ctrl_auto;
  logic [15:0]              oct_reg;
  logic [15:0]              pgd_reg;
  logic [hpf_pkg::IRQ_W-1:0] int_stat;
  logic [hpf_pkg::IRQ_W-1:0] int_mask;
  logic                     wr_pend;
  logic [7:0]               wr_addr;
  logic                     wr_en;
  logic [15:0]              oc_lim;
  logic [15:0]              pg_lim;

  assign wr_en  = wr_pend;
  assign oc_lim = p.oct_prog_open ? hpf_pkg::OC_TIMEOUT_MS : oct_reg;
  assign pg_lim = p.pgd_prog_open ? hpf_pkg::PG_DELAY_MS : pgd_reg;

  // ----------------------------------------------------------------
  // Card present and general input debounce
  // ----------------------------------------------------------------
  logic        present_ok;
  logic [15:0] card_cnt;
  logic [15:0] gen_cnt;

  // Waits one extra tick so the low time is never short of 4 ms
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || p.card_present_n)
    begin
      present_ok <= 1'b0;
      card_cnt   <= 16'h0000;
    end
    else if (tick && !present_ok)
    begin
      if (card_cnt == hpf_pkg::DEBOUNCE_MS)
        present_ok <= 1'b1;
      else
        card_cnt <= card_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      gen_out_o <= 1'b0;
      gen_cnt   <= 16'h0000;
    end
    else if (p.gen_in == gen_out_o)
      gen_cnt <= 16'h0000;
    else if (tick)
    begin
      if (gen_cnt == hpf_pkg::DEBOUNCE_MS)
      begin
        gen_out_o <= p.gen_in;
        gen_cnt   <= 16'h0000;
      end
      else
        gen_cnt <= gen_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Overcurrent timers
  // ----------------------------------------------------------------
  logic [15:0] oc_main_cnt;
  logic [15:0] oc_aux_cnt;
  logic        main_trip;
  logic        aux_trip;

  assign main_trip = tick && p.oc_main && main_on_o && (oc_main_cnt == oc_lim);
  assign aux_trip  = tick && p.oc_aux && aux_on_o && (oc_aux_cnt == oc_lim);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !(p.oc_main && main_on_o))
      oc_main_cnt <= 16'h0000;
    else if (tick && oc_main_cnt != oc_lim)
      oc_main_cnt <= oc_main_cnt + 16'h0001;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !(p.oc_aux && aux_on_o))
      oc_aux_cnt <= 16'h0000;
    else if (tick && oc_aux_cnt != oc_lim)
      oc_aux_cnt <= oc_aux_cnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Fault latch
  // ----------------------------------------------------------------
  hpf_pkg::hpf_fault_t fstate;
  logic                on_low_seen;
  logic                both_low_seen;
  logic [15:0]         restart_cnt;
  logic                restart_done;

  assign restart_done = ctrl_auto && tick && (restart_cnt == hpf_pkg::RESTART_MS);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      fstate        <= hpf_pkg::FLT_NONE;
      on_low_seen   <= 1'b0;
      both_low_seen <= 1'b0;
      restart_cnt   <= 16'h0000;
    end
    else
    begin
      if (tick && restart_cnt != hpf_pkg::RESTART_MS)
        restart_cnt <= restart_cnt + 16'h0001;
      case (fstate)
        hpf_pkg::FLT_NONE:
        begin
          on_low_seen   <= 1'b0;
          both_low_seen <= 1'b0;
          restart_cnt   <= 16'h0000;
          if (p.overtemp || aux_trip)
            fstate <= hpf_pkg::FLT_ALL;
          else if (main_trip)
            fstate <= hpf_pkg::FLT_MAIN;
        end
        hpf_pkg::FLT_MAIN:
        begin
          if (p.overtemp || aux_trip)
          begin
            fstate      <= hpf_pkg::FLT_ALL;
            restart_cnt <= 16'h0000;
          end
          else if (restart_done)
            fstate <= hpf_pkg::FLT_NONE;
          else if (!p.main_enable)
            on_low_seen <= 1'b1;
          else if (on_low_seen)
            fstate <= hpf_pkg::FLT_NONE;
        end
        hpf_pkg::FLT_ALL:
        begin
          // Recovery waits until the die has cooled
          if (p.overtemp)
          begin
            restart_cnt   <= 16'h0000;
            both_low_seen <= 1'b0;
          end
          else if (restart_done)
            fstate <= hpf_pkg::FLT_NONE;
          else if (!p.main_enable && !p.aux_rail_enable)
            both_low_seen <= 1'b1;
          else if (both_low_seen)
            fstate <= hpf_pkg::FLT_NONE;
        end
        default:
          fstate <= hpf_pkg::FLT_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Switch enables
  // ----------------------------------------------------------------
  logic main_go;
  logic aux_go;

  // Force-on also bypasses the fault latch; the analog limit still acts
  assign main_go = (!p.force_all_on_n && p.main_supply_ok)
                || (present_ok && p.main_enable && p.main_supply_ok
                    && fstate == hpf_pkg::FLT_NONE);
  assign aux_go  = !p.force_all_on_n
                || (present_ok && p.aux_rail_enable
                    && fstate != hpf_pkg::FLT_ALL);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      main_on_o      <= 1'b0;
      aux_on_o       <= 1'b0;
      fault_n_oe_o   <= 1'b0;
      fault_n_o      <= 1'b0;
      power_good_n_o <= 1'b0;
    end
    else
    begin
      main_on_o    <= main_go;
      aux_on_o     <= aux_go;
      fault_n_oe_o <= (fstate != hpf_pkg::FLT_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Power good delay
  // ----------------------------------------------------------------
  logic        all_full;
  logic [15:0] pg_cnt;

  assign all_full = main_on_o && aux_on_o && main_go && aux_go
                 && p.main_full && p.aux_full;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !all_full)
    begin
      power_good_n_oe_o <= 1'b0;
      pg_cnt            <= 16'h0000;
    end
    else if (tick && !power_good_n_oe_o)
    begin
      if (pg_cnt == pg_lim)
        power_good_n_oe_o <= 1'b1;
      else
        pg_cnt <= pg_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [hpf_pkg::IRQ_W-1:0] ev;
  logic [hpf_pkg::IRQ_W-1:0] w1c;
  logic                      pg_d;
  logic                      pres_d;

  always_comb
  begin
    ev = '0;
    ev[hpf_pkg::IRQ_FAULT]   = (fstate != hpf_pkg::FLT_NONE) && !fault_n_oe_o;
    ev[hpf_pkg::IRQ_PG_UP]   = power_good_n_oe_o && !pg_d;
    ev[hpf_pkg::IRQ_PG_DOWN] = !power_good_n_oe_o && pg_d;
    ev[hpf_pkg::IRQ_CARD]    = present_ok != pres_d;
  end

  assign w1c = (wr_en && wr_addr == hpf_pkg::ADDR_INT_STAT)
             ? hwdata_i[hpf_pkg::IRQ_W-1:0] : '0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      int_stat <= '0;
      pg_d     <= 1'b0;
      pres_d   <= 1'b0;
      irq_o    <= 1'b0;
    end
    else
    begin
      int_stat <= (int_stat & ~w1c) | ev;
      pg_d     <= power_good_n_oe_o;
      pres_d   <= present_ok;
      irq_o    <= |(((int_stat & ~w1c) | ev) & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic        addr_ok;
  logic [31:0] rd_mux;

  assign addr_ok = hsel_i && htrans_i[1] && hready_i;

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (haddr_i[7:0])
      hpf_pkg::ADDR_CTRL:     rd_mux[0] = ctrl_auto;
      hpf_pkg::ADDR_OC_TIME:  rd_mux[15:0] = oct_reg;
      hpf_pkg::ADDR_PG_DELAY: rd_mux[15:0] = pgd_reg;
      hpf_pkg::ADDR_STATUS:   rd_mux[8:0] = {fstate, gen_out_o, present_ok,
                                             power_good_n_oe_o, fault_n_oe_o,
                                             aux_on_o, main_on_o};
      hpf_pkg::ADDR_INT_STAT: rd_mux[hpf_pkg::IRQ_W-1:0] = int_stat;
      hpf_pkg::ADDR_INT_MASK: rd_mux[hpf_pkg::IRQ_W-1:0] = int_mask;
      default:                rd_mux = 32'h00000000;
    endcase
    if (haddr_i[31:8] != 24'h000000)
      rd_mux = 32'h00000000;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h00000000;
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite_i && (haddr_i[31:8] == 24'h000000);
      wr_addr <= haddr_i[7:0];
      if (addr_ok && !hwrite_i)
        hrdata_o <= rd_mux;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ctrl_auto <= hpf_pkg::RST_AUTO;
      oct_reg   <= hpf_pkg::OC_TIMEOUT_MS;
      pgd_reg   <= hpf_pkg::PG_DELAY_MS;
      int_mask  <= hpf_pkg::RST_INT_MASK;
    end
    else if (wr_en)
    begin
      case (wr_addr)
        hpf_pkg::ADDR_CTRL:     ctrl_auto <= hwdata_i[0];
        hpf_pkg::ADDR_OC_TIME:  oct_reg <= hwdata_i[15:0];
        hpf_pkg::ADDR_PG_DELAY: pgd_reg <= hwdata_i[15:0];
        hpf_pkg::ADDR_INT_MASK: int_mask <= hwdata_i[hpf_pkg::IRQ_W-1:0];
        default:                ;
      endcase
    end
  end

endmodule : hpf_top

`default_nettype wire

// file: design/hpf_pkg.sv
// Package of constants and types for the hot-plug fault and power-good logic
package hpf_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned MS_PER_SEC  = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_SEC;
  localparam logic [15:0] OC_TIMEOUT_MS  = 16'h000B;
  localparam logic [15:0] PG_DELAY_MS    = 16'h00A0;
  localparam logic [15:0] DEBOUNCE_MS    = 16'h0004;
  localparam logic [15:0] RESTART_MS     = 16'h0064;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_OC_TIME   = 8'h04;
  localparam logic [7:0] ADDR_PG_DELAY  = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h14;
  localparam logic       RST_AUTO       = 1'b0;
  localparam logic [3:0] RST_INT_MASK   = 4'h0;

  // Interrupt bit positions
  localparam int IRQ_FAULT   = 0;
  localparam int IRQ_PG_UP   = 1;
  localparam int IRQ_PG_DOWN = 2;
  localparam int IRQ_CARD    = 3;
  localparam int IRQ_W       = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic main_enable;
    logic aux_rail_enable;
    logic card_present_n;
    logic force_all_on_n;
    logic gen_in;
    logic oc_main;
    logic oc_aux;
    logic overtemp;
    logic main_full;
    logic aux_full;
    logic main_supply_ok;
    logic oct_prog_open;
    logic pgd_prog_open;
  } hpf_pins_t;

  localparam int PIN_W = $bits(hpf_pins_t);
  localparam logic [PIN_W-1:0] PIN_IDLE = 13'h0603;  // Pulled-up pins rest high

  typedef enum logic [2:0] {
    FLT_NONE = 3'b001,
    FLT_MAIN = 3'b010,
    FLT_ALL  = 3'b100
  } hpf_fault_t;

endpackage : hpf_pkg

// file: test/hpf_chk.sv
// Concurrent checks on the hot-plug fault and power-good pins
`timescale 1ns/100ps
`default_nettype none
module hpf_chk #(
  parameter int unsigned TICK_CYCLES = 20
) (
  input wire logic core_clk_i,        // Clock
  input wire logic rst_i,             // Reset
  input wire logic card_present_n_i,  // Card present
  input wire logic force_all_on_n_i,  // Force on
  input wire logic main_supply_ok_i,  // Supplies ok
  input wire logic gen_in_i,          // General in
  input wire logic oc_main_i,         // Main overcurrent
  input wire logic oc_aux_i,          // Aux overcurrent
  input wire logic overtemp_i,        // Overtemp
  input wire logic oct_prog_open_i,   // Timeout pin open
  input wire logic pgd_prog_open_i,   // Delay pin open
  input wire logic main_on_o,         // Main rails on
  input wire logic aux_on_o,          // Aux rail on
  input wire logic fault_n_oe_o,      // Fault pulled low
  input wire logic power_good_n_oe_o, // Power good low
  input wire logic gen_out_o          // General out
);
  localparam int unsigned PG_MIN = 160 * TICK_CYCLES - 2;
  localparam int unsigned OC_MIN = 11 * TICK_CYCLES - 2;
  localparam int unsigned DB_MIN = 4 * TICK_CYCLES;
  localparam int unsigned DB_MAX = 5 * TICK_CYCLES + 10;
  logic [31:0] on_cnt;
  logic [31:0] oc_cnt;
  logic [31:0] gen_cnt;
  logic [31:0] card_cnt;
  // ----------------------------------------------------------------
  // Run lengths; pin synchronisers add a few cycles, hence the slack
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
    on_cnt <= (rst_i || !(main_on_o && aux_on_o)) ? 32'h0 : on_cnt + 32'h1;
  always_ff @(posedge core_clk_i)
    oc_cnt <= (rst_i || !(oc_main_i && main_on_o)) ? 32'h0 : oc_cnt + 32'h1;
  always_ff @(posedge core_clk_i)
    gen_cnt <= (rst_i || gen_in_i == gen_out_o) ? 32'h0 : gen_cnt + 32'h1;
  always_ff @(posedge core_clk_i)
    card_cnt <= (rst_i || card_present_n_i) ? 32'h0 : card_cnt + 32'h1;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  a_card_drop_now: assert property (
    (card_present_n_i && force_all_on_n_i) [*7] |-> !main_on_o && !aux_on_o)
    else $error("Rails on after card removal");
  a_card_debounce: assert property (
    $rose(main_on_o) && force_all_on_n_i |-> card_cnt >= DB_MIN)
    else $error("Rails on before card debounce");
  a_force_all_on: assert property (
    (!force_all_on_n_i && main_supply_ok_i) [*8] |-> main_on_o && aux_on_o)
    else $error("Force on ignored");
  a_overtemp_off: assert property (
    (overtemp_i && force_all_on_n_i) [*8] |-> fault_n_oe_o && !main_on_o && !aux_on_o)
    else $error("Overtemp without shutdown");
  a_fault_drops_main: assert property (
    force_all_on_n_i [*7] ##0 $rose(fault_n_oe_o) |-> !main_on_o)
    else $error("Main rails on with fault");
  a_pg_release: assert property (
    !(main_on_o && aux_on_o) |=> !power_good_n_oe_o)
    else $error("Power good held with a rail off");
  a_pg_delay_min: assert property (
    $rose(power_good_n_oe_o) && pgd_prog_open_i |-> on_cnt >= PG_MIN)
    else $error("Power good too early");
  a_oc_timeout_min: assert property (
    $rose(fault_n_oe_o) && oc_main_i && !oc_aux_i && !overtemp_i && oct_prog_open_i
    |-> oc_cnt >= OC_MIN) else $error("Overcurrent fault too early");
  a_gen_debounce_min: assert property (
    $changed(gen_out_o) |-> gen_cnt >= DB_MIN) else $error("General output too early");
  a_gen_debounce_max: assert property (
    gen_cnt <= DB_MAX) else $error("General output too late");
endmodule : hpf_chk
bind hpf_top hpf_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk_i, .rst_i, .card_present_n_i, .force_all_on_n_i, .main_supply_ok_i, .gen_in_i,
  .oc_main_i, .oc_aux_i, .overtemp_i, .oct_prog_open_i, .pgd_prog_open_i, .main_on_o,
  .aux_on_o, .fault_n_oe_o, .power_good_n_oe_o, .gen_out_o
);
`default_nettype wire

// file: test/hpf_ctrl_model.sv
// Model of the management controller that drives the rail enables
`timescale 1ns/100ps
`default_nettype none
module hpf_ctrl_model #(
  parameter int CLR_MIN = 8
) (
  input  wire logic clk_i,     // Clock
  output var  logic main_en_o, // Main enable
  output var  logic aux_en_o   // Aux enable
);
  initial {main_en_o, aux_en_o} = 2'b00;
  task automatic set_en(input logic m, input logic a);
    @(posedge clk_i);
    main_en_o <= m;
    aux_en_o  <= a;
  endtask : set_en
  // Extra low cycles model a slow controller; never shorter than the minimum
  task automatic clear(input logic both, input int extra);
    logic m0;
    logic a0;
    m0 = main_en_o;
    a0 = aux_en_o;
    @(posedge clk_i);
    main_en_o <= 1'b0;
    if (both) aux_en_o <= 1'b0;
    repeat (CLR_MIN + extra) @(posedge clk_i);
    main_en_o <= m0;
    aux_en_o  <= a0;
  endtask : clear
endmodule : hpf_ctrl_model
`default_nettype wire

// file: test/tb_hotplug_fault_powergood_logic.sv
// Self-checking testbench for the hot-plug fault and power-good block
`timescale 1ns/100ps
`default_nettype none
module tb_hotplug_fault_powergood_logic;
  localparam int T = 20;
  localparam int LIMIT = 20000;
  localparam logic [7:0] RA [6] = '{hpf_pkg::ADDR_CTRL, hpf_pkg::ADDR_OC_TIME,
    hpf_pkg::ADDR_PG_DELAY, hpf_pkg::ADDR_INT_MASK, hpf_pkg::ADDR_STATUS, 8'h40};
  localparam logic [31:0] RV [6] = '{32'h0, 32'hB, 32'hA0, 32'h0, 32'h40, 32'h0};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        card_n = 1'b1;
  logic        force_n = 1'b1;
  logic        gen_in = 1'b0;
  logic        oc_m = 1'b0;
  logic        oc_a = 1'b0;
  logic        otemp = 1'b0;
  logic        full = 1'b1;
  logic        oct_open = 1'b1;
  logic        hrdy, hresp, main_en, aux_en, main_on, aux_on, flt_n, flt_oe;
  logic        pg_n, pg_oe, gen_out, irq, flt_pin, pg_pin;
  logic [31:0] hrdata;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  assign flt_pin = flt_oe ? flt_n : 1'b1;
  assign pg_pin = pg_oe ? pg_n : 1'b1;
  always #2.5 clk = ~clk;
  hpf_top #(.TICK_CYCLES(T)) u_dut (
    .core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .main_enable_i(main_en),
    .aux_rail_enable_i(aux_en), .card_present_n_i(card_n), .force_all_on_n_i(force_n),
    .gen_in_i(gen_in), .oc_main_i(oc_m), .oc_aux_i(oc_a), .overtemp_i(otemp),
    .main_full_i(full), .aux_full_i(full), .main_supply_ok_i(1'b1),
    .oct_prog_open_i(oct_open), .pgd_prog_open_i(1'b1), .main_on_o(main_on),
    .aux_on_o(aux_on), .fault_n_o(flt_n), .fault_n_oe_o(flt_oe), .power_good_n_o(pg_n),
    .power_good_n_oe_o(pg_oe), .gen_out_o(gen_out), .irq_o(irq));
  hpf_ctrl_model u_host (.clk_i(clk), .main_en_o(main_en), .aux_en_o(aux_en));
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask : rdchk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  function automatic logic sig(input int k);
    case (k)
      0: sig = main_on;
      1: sig = aux_on;
      2: sig = flt_oe;
      3: sig = pg_oe;
      default: sig = gen_out;
    endcase
  endfunction : sig
  // Waits on a pin level, then checks the cycle count falls in the window
  task automatic expect_in(input int k, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (sig(k) !== lvl && n <= hi)
    begin
      @(negedge clk);
      n++;
    end
    check(n >= lo && n <= hi, 1'b1);
  endtask : expect_in
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      finish_test;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    step(12);
    rst <= 1'b0;
    settle(1);
    check({main_on, aux_on, flt_oe, pg_oe, irq, hrdy}, 32'h1);
    foreach (RA[i]) rdchk(RA[i], RV[i]);
    wr(8'h40, 32'hFFFFFFFF);
    rdchk(8'h40, 32'h0);
    wr(hpf_pkg::ADDR_INT_MASK, 32'h1);
    rdchk(hpf_pkg::ADDR_INT_MASK, 32'h1);
    u_host.set_en(1'b1, 1'b1);
    card_n <= 1'b0;
    expect_in(0, 1'b1, 4 * T, 5 * T + 10);
    check(aux_on, 1'b1);
    expect_in(3, 1'b1, 160 * T - 2, 161 * T + 10);
    check(pg_pin, 1'b0);
    step(1);
    gen_in <= 1'b1;
    step(2 * T);
    gen_in <= 1'b0;
    settle(6 * T);
    check(gen_out, 1'b0);
    step(1);
    gen_in <= 1'b1;
    expect_in(4, 1'b1, 4 * T, 5 * T + 10);
    step(1);
    gen_in <= 1'b0;
    expect_in(4, 1'b0, 4 * T, 5 * T + 10);
    step(1);
    oc_m <= 1'b1;
    expect_in(2, 1'b1, 11 * T, 12 * T + 10);
    settle(2);
    check({main_on, aux_on, pg_oe, flt_pin, irq}, 32'h9);
    step(1);
    oc_m <= 1'b0;
    bus(1'b0, hpf_pkg::ADDR_STATUS, 32'h0, r);
    check(r[8:6], 3'b010);
    settle(4 * T);
    check(flt_oe, 1'b1);
    u_host.clear(1'b0, 0);
    expect_in(2, 1'b0, 0, 20);
    expect_in(0, 1'b1, 0, 20);
    wr(hpf_pkg::ADDR_INT_STAT, 32'hF);
    settle(2);
    check(irq, 1'b0);
    wr(hpf_pkg::ADDR_OC_TIME, 32'h2);
    step(1);
    oct_open <= 1'b0;
    oc_a <= 1'b1;
    expect_in(2, 1'b1, 2 * T, 3 * T + 10);
    settle(2);
    check({main_on, aux_on, irq}, 32'h1);
    step(1);
    oc_a <= 1'b0;
    oct_open <= 1'b1;
    u_host.clear(1'b0, 4);
    settle(4 * T);
    check(flt_oe, 1'b1);
    u_host.clear(1'b1, 0);
    expect_in(2, 1'b0, 0, 20);
    wr(hpf_pkg::ADDR_INT_MASK, 32'h0);
    step(1);
    otemp <= 1'b1;
    expect_in(2, 1'b1, 0, 20);
    settle(2);
    check({main_on, aux_on, irq}, 32'h0);
    step(1);
    otemp <= 1'b0;
    u_host.clear(1'b1, 0);
    expect_in(2, 1'b0, 0, 20);
    bus(1'b0, hpf_pkg::ADDR_INT_STAT, 32'h0, r);
    check(r[0], 1'b1);
    wr(hpf_pkg::ADDR_CTRL, 32'h1);
    step(1);
    oc_m <= 1'b1;
    expect_in(2, 1'b1, 11 * T, 12 * T + 10);
    step(1);
    oc_m <= 1'b0;
    expect_in(2, 1'b0, 100 * T - 2, 101 * T + 10);
    expect_in(0, 1'b1, 0, 10);
    wr(hpf_pkg::ADDR_CTRL, 32'h0);
    step(1);
    card_n <= 1'b1;
    settle(7);
    check({main_on, aux_on, pg_oe}, 32'h0);
    step(1);
    force_n <= 1'b0;
    settle(9);
    check({main_on, aux_on}, 32'h3);
    finish_test;
  end
endmodule : tb_hotplug_fault_powergood_logic
`default_nettype wire
